// >>> hw/dcw_bank.sv
// configuration word bank: nonvolatile words, table access, decoded controls
// assumes a single 10 MHz clock, synchronous active-high reset and a core
// that issues one-cycle table read/write strobes
`timescale 1ns/1ns
`include "dcw_params.svh"

module dcw_bank #(
  parameter int NUM_WORDS = `DCW_NUM_WORDS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // table access port
  input dcw_pkg::dcw_tbl_req_t tbl_req,
  input wire logic prog_hv_entry,
  input wire logic cfg_bulk_erase,
  output logic [7:0] tbl_rdata,
  output logic tbl_rvalid,
  // run-time inputs from the core
  input wire logic sw_watchdog_enable,
  input wire logic sw_brownout_enable,
  input wire logic device_sleeping,
  input wire logic watchdog_clear,
  input wire logic wdt_in_last_quarter,
  // program memory access requests
  input wire logic ext_prog_access,
  input wire logic int_prog_write,
  // decoded controls and gates
  output dcw_pkg::dcw_ctrl_t ctrl,
  output logic watchdog_window_reset,
  output logic ext_prog_grant,
  output logic int_prog_write_grant
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------

  // implemented-bit mask of a word
  function automatic logic [7:0] word_mask(input logic [2:0] idx);
    logic [7:0] m;
    m = 8'h00;
    case (idx)
      `DCW_IDX_SEG: m = `DCW_MASK_SEG;
      `DCW_IDX_OSEL: m = `DCW_MASK_OSEL;
      `DCW_IDX_OSC: m = `DCW_MASK_OSC;
      `DCW_IDX_WDT: m = `DCW_MASK_WDT;
      `DCW_IDX_RST: m = `DCW_MASK_RST;
      `DCW_IDX_DBG: m = `DCW_MASK_DBG;
      `DCW_IDX_DS: m = `DCW_MASK_DS;
      default: m = 8'h00;
    endcase
    return m;
  endfunction : word_mask

  // map a table address to {hit, index}; only even word addresses hit
  function automatic logic [3:0] word_index(input logic [23:0] a);
    logic [23:0] off;
    logic [3:0] r;
    off = a - `DCW_BASE;
    r = 4'h0;
    if (a >= `DCW_ADDR_SEG && a <= `DCW_ADDR_DS && !a[0]) begin
      r = {1'b1, 3'(off[23:1] - 23'h2)};
    end
    return r;
  endfunction : word_index

  // config space test; everything else is user program space
  function automatic logic in_cfg_space(input logic [23:0] a);
    return a >= `DCW_SPACE_LO && a <= `DCW_SPACE_HI;
  endfunction : in_cfg_space

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------

  // nonvolatile words start erased (all implemented bits one)
  logic [7:0] nv_word [NUM_WORDS] = '{`DCW_MASK_SEG, `DCW_MASK_OSEL,
    `DCW_MASK_OSC, `DCW_MASK_WDT, `DCW_MASK_RST, `DCW_MASK_DBG, `DCW_MASK_DS};
  // copy taken at reset that steers the device until the next reset
  logic [7:0] act_word [NUM_WORDS];

  logic [3:0] req_hit;
  logic [2:0] req_idx;
  logic req_cfg;

  assign req_hit = word_index(tbl_req.addr);
  assign req_idx = req_hit[2:0];
  assign req_cfg = in_cfg_space(tbl_req.addr);

  // --------------------------------------------------------------
  // programming
  // --------------------------------------------------------------

  // programming only clears bits; erase is the only way back to one.
  // the reset pin bit is frozen unless high-voltage entry was used, so a
  // low-voltage session cannot lock itself out.
  always_ff @(posedge ref_clk) begin
    if (cfg_bulk_erase) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        nv_word[i] <= word_mask(3'(i));
      end
    end else if (tbl_req.wr && req_cfg && req_hit[3]) begin
      if (req_idx == `DCW_IDX_RST && !prog_hv_entry) begin
        nv_word[req_idx] <= (nv_word[req_idx] & tbl_req.wdata & word_mask(req_idx))
          | (nv_word[req_idx] & 8'h80);
      end else begin
        nv_word[req_idx] <= nv_word[req_idx] & tbl_req.wdata & word_mask(req_idx);
      end
    end
  end

  // --------------------------------------------------------------
  // table read
  // --------------------------------------------------------------

  // one-cycle read latency; holes in config space read zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tbl_rdata <= 8'h00;
      tbl_rvalid <= 1'b0;
    end else begin
      tbl_rvalid <= tbl_req.rd && req_cfg;
      if (tbl_req.rd && req_cfg && req_hit[3]) begin
        tbl_rdata <= nv_word[req_idx] & word_mask(req_idx);
      end else begin
        tbl_rdata <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------
  // latch at reset
  // --------------------------------------------------------------

  // later programming has no effect until the next reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        act_word[i] <= nv_word[i] & word_mask(3'(i));
      end
    end
  end

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------

  logic [7:0] seg_w, osel_w, osc_w, wdt_w, rst_w, dbg_w;
  logic [1:0] cksm, freq, pmd, brownout_enable_select, pair;
  dcw_pkg::dcw_ctrl_t next_ctrl;

  // during reset the controls follow the stored words directly
  assign seg_w = rst ? nv_word[`DCW_IDX_SEG] : act_word[`DCW_IDX_SEG];
  assign osel_w = rst ? nv_word[`DCW_IDX_OSEL] : act_word[`DCW_IDX_OSEL];
  assign osc_w = rst ? nv_word[`DCW_IDX_OSC] : act_word[`DCW_IDX_OSC];
  assign wdt_w = rst ? nv_word[`DCW_IDX_WDT] : act_word[`DCW_IDX_WDT];
  assign rst_w = rst ? nv_word[`DCW_IDX_RST] : act_word[`DCW_IDX_RST];
  assign dbg_w = rst ? nv_word[`DCW_IDX_DBG] : act_word[`DCW_IDX_DBG];
  assign cksm = osc_w[`DCW_OSC_CKSM +: 2];
  assign freq = osc_w[`DCW_OSC_FREQ +: 2];
  assign pmd = osc_w[`DCW_OSC_PMD +: 2];
  assign brownout_enable_select = rst_w[`DCW_RST_BROWNOUT_ENABLE_SELECT +: 2];
  assign pair = dbg_w[`DCW_DBG_PAIR +: 2];

  // field meanings; bits are active low where programming enables a feature
  always_comb begin
    next_ctrl = '0;
    next_ctrl.code_protect_on = !seg_w[`DCW_SEG_CP];
    next_ctrl.write_protect_on = !seg_w[`DCW_SEG_WP];
    next_ctrl.two_speed_startup_enable = osel_w[`DCW_OSEL_TWO_SPEED_STARTUP_ENABLE];
    next_ctrl.startup_osc_select = dcw_pkg::dcw_osc_src_t'(osel_w[`DCW_OSEL_NOSC +: 3]);
    next_ctrl.clock_switch_enable = !cksm[1];
    next_ctrl.fail_safe_monitor_enable = (cksm == 2'b00);
    next_ctrl.secondary_osc_high_power = osc_w[`DCW_OSC_SECONDARY_OSC];
    next_ctrl.primary_freq_range = freq;
    next_ctrl.freq_range_reserved = (freq == 2'b00);
    next_ctrl.clock_out_enable = osc_w[`DCW_OSC_CLOCK_OUTPUT]
      && (pmd == 2'b11 || pmd == 2'b00);
    next_ctrl.primary_osc_mode = dcw_pkg::dcw_prim_mode_t'(pmd);
    next_ctrl.watchdog_enabled = wdt_w[`DCW_WDT_EN] || sw_watchdog_enable;
    next_ctrl.window_enable = !wdt_w[`DCW_WDT_WIN];
    next_ctrl.prescale_log2 = wdt_w[`DCW_WDT_PSA] ? `DCW_PRE_LOG2_HI : `DCW_PRE_LOG2_LO;
    next_ctrl.postscale_log2 = wdt_w[`DCW_WDT_PS +: 4];
    next_ctrl.reset_pin_enable = rst_w[`DCW_RST_PIN];
    next_ctrl.brownout_level_select = rst_w[`DCW_RST_BROWNOUT_LEVEL_SELECT +: 2];
    next_ctrl.powerup_timer_enable = rst_w[`DCW_RST_POWERUP_TIMER];
    case (brownout_enable_select)
      2'b11: next_ctrl.brownout_reset_on = 1'b1;
      2'b10: next_ctrl.brownout_reset_on = !device_sleeping;
      2'b01: next_ctrl.brownout_reset_on = sw_brownout_enable;
      default: next_ctrl.brownout_reset_on = 1'b0;
    endcase
    next_ctrl.prog_pin_pair_two = (pair == 2'b10);
    next_ctrl.prog_pin_pair_three = (pair == 2'b01);
    next_ctrl.debug_pair_reserved = (pair == 2'b00 || pair == 2'b11);
    next_ctrl.deep_sleep_word = rst ? nv_word[`DCW_IDX_DS] : act_word[`DCW_IDX_DS];
  end

  // registered so the controls are glitch-free across the chip
  always_ff @(posedge ref_clk) begin
    ctrl <= next_ctrl;
  end

  // --------------------------------------------------------------
  // watchdog window check
  // --------------------------------------------------------------

  // an early clear in windowed mode is treated like a time-out
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      watchdog_window_reset <= 1'b0;
    end else begin
      watchdog_window_reset <= watchdog_clear && ctrl.window_enable
        && ctrl.watchdog_enabled && !wdt_in_last_quarter;
    end
  end

  // --------------------------------------------------------------
  // program memory protection
  // --------------------------------------------------------------

  // code protection only stops the external port; execution is untouched
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_prog_grant <= 1'b0;
      int_prog_write_grant <= 1'b0;
    end else begin
      ext_prog_grant <= ext_prog_access && !ctrl.code_protect_on;
      int_prog_write_grant <= int_prog_write && !ctrl.write_protect_on;
    end
  end

endmodule : dcw_bank

// >>> hw/dcw_params.svh
// constants for the configuration word bank: addresses, field positions, masks
// assumes a 24-bit table address and 8-bit configuration words
`ifndef DCW_PARAMS_SVH
`define DCW_PARAMS_SVH

// --------------------------------------------------------------
// address map
// --------------------------------------------------------------
`define DCW_SPACE_LO 24'h800000
`define DCW_SPACE_HI 24'hFFFFFF
`define DCW_BASE 24'hF80000
`define DCW_ADDR_SEG 24'hF80004
`define DCW_ADDR_OSEL 24'hF80006
`define DCW_ADDR_OSC 24'hF80008
`define DCW_ADDR_WDT 24'hF8000A
`define DCW_ADDR_RST 24'hF8000C
`define DCW_ADDR_DBG 24'hF8000E
`define DCW_ADDR_DS 24'hF80010
`define DCW_NUM_WORDS 7

// --------------------------------------------------------------
// word indices and implemented-bit masks (erased value = mask)
// --------------------------------------------------------------
`define DCW_IDX_SEG 3'h0
`define DCW_IDX_OSEL 3'h1
`define DCW_IDX_OSC 3'h2
`define DCW_IDX_WDT 3'h3
`define DCW_IDX_RST 3'h4
`define DCW_IDX_DBG 3'h5
`define DCW_IDX_DS 3'h6
`define DCW_MASK_SEG 8'h03
`define DCW_MASK_OSEL 8'h87
`define DCW_MASK_OSC 8'hFF
`define DCW_MASK_WDT 8'hDF
`define DCW_MASK_RST 8'hEB
`define DCW_MASK_DBG 8'h03
`define DCW_MASK_DS 8'hCF

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define DCW_SEG_CP 1
`define DCW_SEG_WP 0
`define DCW_OSEL_TWO_SPEED_STARTUP_ENABLE 7
`define DCW_OSEL_NOSC 0
`define DCW_OSC_CKSM 6
`define DCW_OSC_SECONDARY_OSC 5
`define DCW_OSC_FREQ 3
`define DCW_OSC_CLOCK_OUTPUT 2
`define DCW_OSC_PMD 0
`define DCW_WDT_EN 7
`define DCW_WDT_WIN 6
`define DCW_WDT_PSA 4
`define DCW_WDT_PS 0
`define DCW_RST_PIN 7
`define DCW_RST_BROWNOUT_LEVEL_SELECT 5
`define DCW_RST_POWERUP_TIMER 3
`define DCW_RST_BROWNOUT_ENABLE_SELECT 0
`define DCW_DBG_PAIR 0

// --------------------------------------------------------------
// watchdog prescaler ratios as powers of two (1:128, 1:32)
// --------------------------------------------------------------
`define DCW_PRE_LOG2_HI 3'h7
`define DCW_PRE_LOG2_LO 3'h5

`endif

// >>> hw/dcw_pkg.sv
// types shared by the configuration word bank and its users
// assumes dcw_params.svh supplies the numbers
package dcw_pkg;

  typedef enum logic [2:0] {
    DCW_OSC_FAST_RC = 3'b000,
    DCW_OSC_FAST_RC_DIV_PLL = 3'b001,
    DCW_OSC_PRIMARY = 3'b010,
    DCW_OSC_PRIMARY_PLL = 3'b011,
    DCW_OSC_SECONDARY = 3'b100,
    DCW_OSC_LOW_POWER_RC = 3'b101,
    DCW_OSC_LOW_POWER_FAST_RC_DIV = 3'b110,
    DCW_OSC_FAST_RC_DIV = 3'b111
  } dcw_osc_src_t;

  typedef enum logic [1:0] {
    DCW_PM_EXT_CLOCK = 2'b00,
    DCW_PM_STD_CRYSTAL = 2'b01,
    DCW_PM_HIGH_SPEED_CRYSTAL = 2'b10,
    DCW_PM_DISABLED = 2'b11
  } dcw_prim_mode_t;

  // table access request from the core
  typedef struct packed {
    logic [23:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } dcw_tbl_req_t;

  // decoded device-wide settings
  typedef struct packed {
    logic code_protect_on;
    logic write_protect_on;
    logic two_speed_startup_enable;
    dcw_osc_src_t startup_osc_select;
    logic clock_switch_enable;
    logic fail_safe_monitor_enable;
    logic secondary_osc_high_power;
    logic [1:0] primary_freq_range;
    logic freq_range_reserved;
    logic clock_out_enable;
    dcw_prim_mode_t primary_osc_mode;
    logic watchdog_enabled;
    logic window_enable;
    logic [2:0] prescale_log2;
    logic [3:0] postscale_log2;
    logic reset_pin_enable;
    logic [1:0] brownout_level_select;
    logic powerup_timer_enable;
    logic brownout_reset_on;
    logic prog_pin_pair_two;
    logic prog_pin_pair_three;
    logic debug_pair_reserved;
    logic [7:0] deep_sleep_word;
  } dcw_ctrl_t;

endpackage : dcw_pkg

// >>> sim/dcw_bank_monitor.sv
// checker for the configuration word bank, watching only the bank's ports
// assumes binding from the bench top and the shared address header
`timescale 1ns/1ns
`include "dcw_params.svh"

module dcw_bank_monitor #(
  parameter int NUM_WORDS = `DCW_NUM_WORDS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // table port
  input dcw_pkg::dcw_tbl_req_t tbl_req,
  input wire logic [7:0] tbl_rdata,
  input wire logic tbl_rvalid,
  // watchdog and protection
  input wire logic watchdog_clear,
  input wire logic wdt_in_last_quarter,
  input wire logic ext_prog_access,
  input wire logic int_prog_write,
  input dcw_pkg::dcw_ctrl_t ctrl,
  input wire logic watchdog_window_reset,
  input wire logic ext_prog_grant,
  input wire logic int_prog_write_grant
);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_cfg_read;
    tbl_req.rd && tbl_req.addr >= `DCW_SPACE_LO;
  endsequence
  sequence s_early_clear;
    watchdog_clear && ctrl.window_enable && ctrl.watchdog_enabled && !wdt_in_last_quarter;
  endsequence
  // three quiet edges, so the reset copy has surely landed in ctrl
  sequence s_settled;
    !rst [*3];
  endsequence

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_read_answer: assert property (s_cfg_read |=> tbl_rvalid)
    else $error("in-space read gave no answer");
  chk_read_outside: assert property (tbl_req.rd && tbl_req.addr < `DCW_SPACE_LO |=> !tbl_rvalid)
    else $error("out-of-space read answered");
  chk_rvalid_cause: assert property (tbl_rvalid |-> $past(tbl_req.rd))
    else $error("answer without a read");
  chk_odd_zero: assert property (s_cfg_read ##0 tbl_req.addr[0] |=> tbl_rdata == 8'h00)
    else $error("odd address read not zero");
  chk_seg_unused: assert property (s_cfg_read ##0 tbl_req.addr == `DCW_ADDR_SEG |=> tbl_rdata[7:2] == 6'h00)
    else $error("unused protection bits not zero");
  chk_window_reset: assert property (s_early_clear |=> watchdog_window_reset)
    else $error("early clear gave no watchdog reset");
  chk_window_cause: assert property (watchdog_window_reset |-> $past(watchdog_clear) && !$past(wdt_in_last_quarter))
    else $error("watchdog reset without early clear");
  chk_ext_grant: assert property (ext_prog_grant == ($past(ext_prog_access) && !$past(ctrl.code_protect_on)))
    else $error("external access grant wrong");
  chk_int_grant: assert property (int_prog_write_grant == ($past(int_prog_write) && !$past(ctrl.write_protect_on)))
    else $error("internal write grant wrong");
  chk_ctrl_static: assert property (s_settled |-> $stable(ctrl.startup_osc_select) && $stable(ctrl.reset_pin_enable))
    else $error("latched control moved between resets");
  chk_pair_select: assert property (ctrl.debug_pair_reserved == (ctrl.prog_pin_pair_two == ctrl.prog_pin_pair_three))
    else $error("pin pair flags inconsistent");
  chk_clock_out_mode: assert property (ctrl.clock_out_enable |-> ctrl.primary_osc_mode[1] == ctrl.primary_osc_mode[0])
    else $error("clock out with crystal mode");
endmodule : dcw_bank_monitor

// >>> sim/tb.sv
// self-checking bench for the configuration word bank
// assumes the bank, its package and the address header are compiled first
`timescale 1ns/1ns
`include "dcw_params.svh"

module tb;
  // ------------------------------------------------------------
  // stimulus and model state
  // ------------------------------------------------------------
  logic ref_clk = 0;
  logic rst = 1;
  dcw_pkg::dcw_tbl_req_t tbl_req = '0;
  logic prog_hv_entry = 0;
  logic cfg_bulk_erase = 0;
  logic sw_watchdog_enable = 0;
  logic sw_brownout_enable = 0;
  logic device_sleeping = 0;
  logic watchdog_clear = 0;
  logic wdt_in_last_quarter = 0;
  logic ext_prog_access = 0;
  logic int_prog_write = 0;
  logic [7:0] tbl_rdata;
  logic tbl_rvalid;
  dcw_pkg::dcw_ctrl_t ctrl;
  logic watchdog_window_reset;
  logic ext_prog_grant;
  logic int_prog_write_grant;
  logic [7:0] mask [7] = '{`DCW_MASK_SEG, `DCW_MASK_OSEL, `DCW_MASK_OSC, `DCW_MASK_WDT, `DCW_MASK_RST,
    `DCW_MASK_DBG, `DCW_MASK_DS};
  logic [7:0] ew [7];
  logic [31:0] seed = 32'd76576;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;

  dcw_bank DUT (.ref_clk(ref_clk), .rst(rst), .tbl_req(tbl_req), .prog_hv_entry(prog_hv_entry),
    .cfg_bulk_erase(cfg_bulk_erase), .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid),
    .sw_watchdog_enable(sw_watchdog_enable), .sw_brownout_enable(sw_brownout_enable),
    .device_sleeping(device_sleeping), .watchdog_clear(watchdog_clear),
    .wdt_in_last_quarter(wdt_in_last_quarter), .ext_prog_access(ext_prog_access),
    .int_prog_write(int_prog_write), .ctrl(ctrl), .watchdog_window_reset(watchdog_window_reset),
    .ext_prog_grant(ext_prog_grant), .int_prog_write_grant(int_prog_write_grant));

  // 100 ns period; hang guard well above the few hundred cycles needed
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // decode of the stored words, as the settings should come out
  function automatic dcw_pkg::dcw_ctrl_t exp_ctrl();
    dcw_pkg::dcw_ctrl_t c;
    c.code_protect_on = ~ew[0][1];
    c.write_protect_on = ~ew[0][0];
    c.two_speed_startup_enable = ew[1][7];
    c.startup_osc_select = dcw_pkg::dcw_osc_src_t'(ew[1][2:0]);
    c.clock_switch_enable = ~ew[2][7];
    c.fail_safe_monitor_enable = ew[2][7:6] == 2'h0;
    c.secondary_osc_high_power = ew[2][5];
    c.primary_freq_range = ew[2][4:3];
    c.freq_range_reserved = ew[2][4:3] == 2'h0;
    c.clock_out_enable = ew[2][2] && ew[2][1] == ew[2][0];
    c.primary_osc_mode = dcw_pkg::dcw_prim_mode_t'(ew[2][1:0]);
    c.watchdog_enabled = ew[3][7] | sw_watchdog_enable;
    c.window_enable = ~ew[3][6];
    c.prescale_log2 = ew[3][4] ? 3'h7 : 3'h5;
    c.postscale_log2 = ew[3][3:0];
    c.reset_pin_enable = ew[4][7];
    c.brownout_level_select = ew[4][6:5];
    c.powerup_timer_enable = ew[4][3];
    case (ew[4][1:0])
      2'h3: c.brownout_reset_on = 1'b1;
      2'h2: c.brownout_reset_on = ~device_sleeping;
      2'h1: c.brownout_reset_on = sw_brownout_enable;
      default: c.brownout_reset_on = 1'b0;
    endcase
    c.prog_pin_pair_two = ew[5][1:0] == 2'h2;
    c.prog_pin_pair_three = ew[5][1:0] == 2'h1;
    c.debug_pair_reserved = ew[5][1] == ew[5][0];
    c.deep_sleep_word = ew[6];
    return c;
  endfunction : exp_ctrl

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic do_reset();
    rst = 1;
    repeat (12) step();
    rst = 0;
    repeat (2) step();
  endtask : do_reset

  task automatic rd_word(input logic [23:0] a, input logic v, input logic [7:0] d);
    tbl_req.addr = a;
    tbl_req.rd = 1;
    step();
    tbl_req.rd = 0;
    chk("tbl_rvalid", 64'(v), 64'(tbl_rvalid));
    if (v) chk("tbl_rdata", 64'(d), 64'(tbl_rdata));
    // idle edge so the next call never re-raises the strobe in this time step
    step();
  endtask : rd_word

  // programming only clears bits; the reset-pin bit survives without high-voltage entry
  task automatic wr_word(input int i, input logic [7:0] d);
    tbl_req.addr = `DCW_ADDR_SEG + 24'(2 * i);
    tbl_req.wdata = d;
    tbl_req.wr = 1;
    step();
    tbl_req.wr = 0;
    ew[i] &= d | ((i == 4 && !prog_hv_entry) ? 8'h80 : 8'h00);
    step();
  endtask : wr_word

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d;
    ew = mask;
    do_reset();
    // erased words, holes in the space and addresses outside it
    for (int i = 0; i < 7; i++) rd_word(`DCW_ADDR_SEG + 24'(2 * i), 1, mask[i]);
    rd_word(`DCW_BASE, 1, 8'h00);
    rd_word(`DCW_ADDR_OSC + 24'h1, 1, 8'h00);
    rd_word(24'h7FFFFE, 0, 8'h00);
    chk("ctrl", 64'(exp_ctrl()), 64'(ctrl));
    $display("test erased done");
    // each round pins one code of the start-up oscillator, range, mode, window, brownout-enable and pin-pair fields and randomises the rest
    for (int r = 0; r < 8; r++) begin
      cfg_bulk_erase = 1;
      step();
      cfg_bulk_erase = 0;
      ew = mask;
      for (int i = 0; i < 7; i++) begin
        d = 8'(xs());
        prog_hv_entry = d[2];
        if (i == 1) d[2:0] = r[2:0];
        // software keeps off the reserved codes of the range and pin-pair fields
        if (i == 2) d[4:0] = {r[2], r[1] | ~r[2], d[2], r[1:0]};
        if (i == 3) d[6] = r[0];
        if (i == 4) d[1:0] = r[1:0];
        if (i == 5) d[1:0] = {r[0], ~r[0]};
        wr_word(i, d);
      end
      tbl_req.addr = 24'(xs()) & 24'h7FFFFE;
      tbl_req.wdata = 8'h00;
      tbl_req.wr = 1;
      step();
      tbl_req.wr = 0;
      for (int i = 0; i < 7; i++) rd_word(`DCW_ADDR_SEG + 24'(2 * i), 1, ew[i]);
      d = 8'(xs());
      {sw_watchdog_enable, sw_brownout_enable, device_sleeping} = d[2:0];
      do_reset();
      chk("ctrl", 64'(exp_ctrl()), 64'(ctrl));
      {sw_watchdog_enable, sw_brownout_enable, device_sleeping} = d[5:3];
      step();
      chk("ctrl live", 64'(exp_ctrl()), 64'(ctrl));
      {ext_prog_access, int_prog_write} = 2'h3;
      step();
      {ext_prog_access, int_prog_write} = 2'h0;
      chk("ext_prog_grant", 64'(ew[0][1]), 64'(ext_prog_grant));
      chk("int_prog_write_grant", 64'(ew[0][0]), 64'(int_prog_write_grant));
      watchdog_clear = 1;
      wdt_in_last_quarter = d[6];
      step();
      watchdog_clear = 0;
      chk("watchdog_window_reset", 64'(~ew[3][6] & exp_ctrl().watchdog_enabled & ~d[6]),
        64'(watchdog_window_reset));
      $display("test round %0d done", r);
    end
    finish_test();
  end
endmodule : tb

bind dcw_bank dcw_bank_monitor #(.NUM_WORDS(NUM_WORDS)) mon (.ref_clk(ref_clk), .rst(rst), .tbl_req(tbl_req),
  .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid), .watchdog_clear(watchdog_clear),
  .wdt_in_last_quarter(wdt_in_last_quarter), .ext_prog_access(ext_prog_access),
  .int_prog_write(int_prog_write), .ctrl(ctrl), .watchdog_window_reset(watchdog_window_reset),
  .ext_prog_grant(ext_prog_grant), .int_prog_write_grant(int_prog_write_grant));
